/* hdl/flash_host.sv */
// Purpose: Host sequencer driving a serial flash through its pins
// Assumes: flash_so comes from the pin and is synchronised here
// Notes:   One user command at a time; cmd_ready high when idle
module flash_host (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                cmd_valid,
  input  wire flash_pkg::user_op_t cmd_op,
  input  wire logic [23:0]         cmd_addr,
  input  wire logic [15:0]         cmd_wdata,
  input  wire logic [15:0]         cmd_len,
  input  wire logic                hw_detect,
  output logic                     cmd_ready,
  output logic [7:0]               rd_data,
  output logic                     rd_valid,
  output logic                     done,
  output logic                     err,
  output logic                     aai_active,
  output logic                     flash_cs_n,
  output logic                     flash_sck,
  output logic                     flash_si,
  input  wire logic                flash_so
);
  flash_pkg::host_state_t st_q;
  flash_pkg::frame_kind_t kind_q;
  flash_pkg::frame_kind_t start_kind;
  flash_pkg::frame_kind_t next_kind;
  flash_pkg::user_op_t    op_q;

  logic [23:0] addr_q;
  logic [23:0] ptr_q;
  logic [15:0] wdata_q;
  logic [15:0] len_q;
  logic [15:0] rd_left_q;
  logic [7:0]  cnt_q;
  logic [7:0]  rd_data_q;
  logic [2:0]  idx_q;
  logic        hw_q;
  logic        aai_q;
  logic        stat_busy_q;
  logic        cs_n_q;
  logic        cmd_ready_q;
  logic        rd_valid_q;
  logic        done_q;
  logic        err_q;
  logic        eng_start_q;
  logic        so_m_q;
  logic        so_s_q;
  logic        write_enable_cmd_seen_q;
  logic        busy_on_output_enable_cmd_seen_q;

  logic        eng_done;
  logic        eng_busy;
  logic [7:0]  eng_rx;
  logic [7:0]  main_op;
  logic [7:0]  frame_op;
  logic [7:0]  b4;
  logic [7:0]  tx_byte;
  logic [23:0] eff_addr;
  logic [47:0] frame_hdr;
  logic [47:0] hdr_shift;
  logic [2:0]  frame_len;
  logic [15:0] frame_rd;

  // Command acceptance
  wire accept     = cmd_valid && cmd_ready_q;
  wire is_aai_cmd = (cmd_op == flash_pkg::OP_AAI_NEXT) || (cmd_op == flash_pkg::OP_AAI_END);
  wire past_top   = ptr_q > flash_pkg::TOP_ADDRESS;
  wire cmd_bad    = (aai_q != is_aai_cmd)
                 || ((cmd_op == flash_pkg::OP_AAI_NEXT) && past_top)
                 || ((cmd_op == flash_pkg::OP_READ) && (cmd_len == 16'h0000));

  assign start_kind = ((cmd_op == flash_pkg::OP_READ) || (cmd_op == flash_pkg::OP_AAI_NEXT))
                    ? flash_pkg::K_MAIN
                    : (cmd_op == flash_pkg::OP_AAI_END) ? flash_pkg::K_WRITE_DISABLE_CMD
                    : ((cmd_op == flash_pkg::OP_AAI_FIRST) && hw_detect) ? flash_pkg::K_BUSY_ON_OUTPUT_ENABLE_CMD
                    : flash_pkg::K_WRITE_ENABLE_CMD;

  // Frame contents
  assign main_op = (op_q == flash_pkg::OP_READ)   ? flash_pkg::FAST_READ_CMD
                 : (op_q == flash_pkg::OP_BYTE)   ? flash_pkg::BYTE_PROGRAM_CMD
                 : (op_q == flash_pkg::OP_SECTOR) ? flash_pkg::SECTOR_ERASE_CMD
                 : (op_q == flash_pkg::OP_BLK32)  ? flash_pkg::BLOCK32_ERASE_CMD
                 : (op_q == flash_pkg::OP_BLK64)  ? flash_pkg::BLOCK64_ERASE_CMD
                 : flash_pkg::AAI_WORD_CMD;

  assign frame_op = (kind_q == flash_pkg::K_WRITE_ENABLE_CMD) ? flash_pkg::WRITE_ENABLE_CMD
                  : (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_ENABLE_CMD) ? flash_pkg::BUSY_ON_OUTPUT_ENABLE_CMD
                  : (kind_q == flash_pkg::K_POLL) ? flash_pkg::READ_STATUS_CMD
                  : (kind_q == flash_pkg::K_WRITE_DISABLE_CMD) ? flash_pkg::WRITE_DISABLE_CMD
                  : (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_DISABLE_CMD) ? flash_pkg::BUSY_ON_OUTPUT_DISABLE_CMD
                  : main_op;

  assign eff_addr = (op_q == flash_pkg::OP_SECTOR)    ? (addr_q & flash_pkg::SECTOR_MASK)
                  : (op_q == flash_pkg::OP_BLK32)     ? (addr_q & flash_pkg::BLOCK32_MASK)
                  : (op_q == flash_pkg::OP_BLK64)     ? (addr_q & flash_pkg::BLOCK64_MASK)
                  : (op_q == flash_pkg::OP_AAI_FIRST) ? (addr_q & flash_pkg::WORD_MASK)
                  : addr_q;

  assign b4 = (op_q == flash_pkg::OP_READ) ? flash_pkg::DUMMY_BYTE
            : (op_q == flash_pkg::OP_BYTE) ? wdata_q[7:0]
            : wdata_q[15:8];

  wire has_addr = (kind_q == flash_pkg::K_MAIN) && (op_q != flash_pkg::OP_AAI_NEXT);

  assign frame_hdr = has_addr ? {frame_op, eff_addr, b4, wdata_q[7:0]}
                              : {frame_op, wdata_q, 24'h000000};

  assign frame_len = (kind_q != flash_pkg::K_MAIN) ? flash_pkg::HDR_LEN_SHORT
                   : ((op_q == flash_pkg::OP_READ) || (op_q == flash_pkg::OP_BYTE))
                     ? flash_pkg::HDR_LEN_READ
                   : (op_q == flash_pkg::OP_AAI_FIRST) ? flash_pkg::HDR_LEN_AAI_FIRST
                   : (op_q == flash_pkg::OP_AAI_NEXT)  ? flash_pkg::HDR_LEN_AAI_NEXT
                   : flash_pkg::HDR_LEN_ERASE;

  assign frame_rd = (kind_q == flash_pkg::K_POLL) ? 16'h0001
                  : ((kind_q == flash_pkg::K_MAIN) && (op_q == flash_pkg::OP_READ)) ? len_q
                  : 16'h0000;

  wire rd_phase = idx_q >= frame_len;
  assign hdr_shift = frame_hdr << {idx_q, 3'b000};
  assign tx_byte   = rd_phase ? flash_pkg::DUMMY_BYTE : hdr_shift[47:40];

  wire more = rd_phase ? (rd_left_q > 16'h0001)
                       : (((idx_q + 3'h1) < frame_len) || (rd_left_q != 16'h0000));

  // Sequencing between frames
  wire setup_end = cnt_q == flash_pkg::CS_SETUP_LAST;
  wire gap_end   = cnt_q == flash_pkg::CS_HIGH_LAST;
  // Busy wait: let released-pin level leave the synchroniser first
  wire sync_end  = cnt_q == (flash_pkg::CS_SETUP_LAST + 8'h02);
  wire aai_op    = (op_q == flash_pkg::OP_AAI_FIRST) || (op_q == flash_pkg::OP_AAI_NEXT);
  wire go_hww    = (kind_q == flash_pkg::K_MAIN) && hw_q && aai_op;
  wire finish    = ((kind_q == flash_pkg::K_MAIN) && (op_q == flash_pkg::OP_READ))
                || ((kind_q == flash_pkg::K_POLL) && !stat_busy_q)
                || ((kind_q == flash_pkg::K_WRITE_DISABLE_CMD) && !hw_q)
                || (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_DISABLE_CMD);

  assign next_kind = (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_ENABLE_CMD) ? flash_pkg::K_WRITE_ENABLE_CMD
                   : (kind_q == flash_pkg::K_WRITE_ENABLE_CMD) ? flash_pkg::K_MAIN
                   : (kind_q == flash_pkg::K_WRITE_DISABLE_CMD) ? flash_pkg::K_BUSY_ON_OUTPUT_DISABLE_CMD
                   : flash_pkg::K_POLL;

  // Serial output synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      so_m_q <= 1'b0;
      so_s_q <= 1'b0;
    end else begin
      so_m_q <= flash_so;
      so_s_q <= so_m_q;
    end
  end

  spi_byte_shifter u_shift (
    .clk     (clk),
    .rst     (rst),
    .start   (eng_start_q),
    .tx_byte (tx_byte),
    .miso    (so_s_q),
    .sck     (flash_sck),
    .mosi    (flash_si),
    .rx_byte (eng_rx),
    .done    (eng_done),
    .busy    (eng_busy)
  );

  // Main sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q        <= flash_pkg::ST_IDLE;
      kind_q      <= flash_pkg::K_WRITE_ENABLE_CMD;
      op_q        <= flash_pkg::OP_READ;
      addr_q      <= 24'h000000;
      ptr_q       <= 24'h000000;
      wdata_q     <= 16'h0000;
      len_q       <= 16'h0000;
      rd_left_q   <= 16'h0000;
      cnt_q       <= 8'h00;
      rd_data_q   <= 8'h00;
      idx_q       <= 3'h0;
      hw_q        <= 1'b0;
      aai_q       <= 1'b0;
      stat_busy_q <= 1'b0;
      cs_n_q      <= 1'b1;
      cmd_ready_q <= 1'b1;
      rd_valid_q  <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      eng_start_q <= 1'b0;
      write_enable_cmd_seen_q <= 1'b0;
      busy_on_output_enable_cmd_seen_q <= 1'b0;
    end else begin
      rd_valid_q  <= 1'b0;
      done_q      <= 1'b0;
      err_q       <= 1'b0;
      eng_start_q <= 1'b0;
      cnt_q       <= cnt_q + 8'h01;
      case (st_q)
        flash_pkg::ST_IDLE: begin
          if (accept && cmd_bad) begin
            err_q <= 1'b1;
          end else if (accept) begin
            cmd_ready_q <= 1'b0;
            op_q        <= cmd_op;
            addr_q      <= cmd_addr;
            wdata_q     <= cmd_wdata;
            len_q       <= cmd_len;
            kind_q      <= start_kind;
            if (cmd_op == flash_pkg::OP_AAI_FIRST) hw_q <= hw_detect;
            cs_n_q      <= 1'b0;
            cnt_q       <= 8'h00;
            st_q        <= flash_pkg::ST_CSLO;
          end
        end
        flash_pkg::ST_CSLO: begin
          if (setup_end) begin
            rd_left_q   <= frame_rd;
            idx_q       <= 3'h0;
            eng_start_q <= 1'b1;
            st_q        <= flash_pkg::ST_BYTE;
          end
        end
        flash_pkg::ST_BYTE: begin
          if (eng_done) begin
            if (rd_phase) begin
              rd_data_q  <= eng_rx;
              rd_valid_q <= kind_q == flash_pkg::K_MAIN;
              if (kind_q == flash_pkg::K_POLL) stat_busy_q <= eng_rx[flash_pkg::STAT_BUSY_BIT];
              rd_left_q  <= rd_left_q - 16'h0001;
            end
            if (more) begin
              eng_start_q <= 1'b1;
              if (!rd_phase) idx_q <= idx_q + 3'h1;
            end else begin
              cs_n_q <= 1'b1;
              cnt_q  <= 8'h00;
              st_q   <= flash_pkg::ST_CSHI;
            end
          end
        end
        flash_pkg::ST_CSHI: begin
          if (gap_end) begin
            if (kind_q == flash_pkg::K_WRITE_ENABLE_CMD) write_enable_cmd_seen_q <= 1'b1;
            if (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_ENABLE_CMD) busy_on_output_enable_cmd_seen_q <= 1'b1;
            if (kind_q == flash_pkg::K_WRITE_DISABLE_CMD) aai_q <= 1'b0;
            if ((kind_q == flash_pkg::K_MAIN) && (op_q == flash_pkg::OP_AAI_FIRST)) begin
              aai_q <= 1'b1;
              ptr_q <= eff_addr + flash_pkg::AAI_WORD_STEP;
            end
            if ((kind_q == flash_pkg::K_MAIN) && (op_q == flash_pkg::OP_AAI_NEXT)) begin
              ptr_q <= ptr_q + flash_pkg::AAI_WORD_STEP;
            end
            cnt_q <= 8'h00;
            if (go_hww) begin
              cs_n_q <= 1'b0;
              st_q   <= flash_pkg::ST_HWW;
            end else if (finish) begin
              done_q      <= 1'b1;
              cmd_ready_q <= 1'b1;
              write_enable_cmd_seen_q <= 1'b0;
              busy_on_output_enable_cmd_seen_q <= 1'b0;
              st_q        <= flash_pkg::ST_IDLE;
            end else begin
              kind_q <= next_kind;
              cs_n_q <= 1'b0;
              st_q   <= flash_pkg::ST_CSLO;
            end
          end
        end
        flash_pkg::ST_HWW: begin
          if (!sync_end) begin
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= cnt_q;
            if (so_s_q) begin
              stat_busy_q <= 1'b0;
              kind_q      <= flash_pkg::K_POLL;
              cs_n_q      <= 1'b1;
              cnt_q       <= 8'h00;
              st_q        <= flash_pkg::ST_CSHI;
            end
          end
        end
        default: begin
          st_q <= flash_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign cmd_ready  = cmd_ready_q;
  assign rd_data    = rd_data_q;
  assign rd_valid   = rd_valid_q;
  assign done       = done_q;
  assign err        = err_q;
  assign aai_active = aai_q;
  assign flash_cs_n = cs_n_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  wire frame_go  = (st_q == flash_pkg::ST_CSLO) && setup_end;
  wire main_wr   = (op_q != flash_pkg::OP_READ) && (op_q != flash_pkg::OP_AAI_NEXT);

  property p_write_enable_cmd_first;
    frame_go && (kind_q == flash_pkg::K_MAIN) && main_wr |-> write_enable_cmd_seen_q;
  endproperty
  a_write_enable_cmd_first : assert property (p_write_enable_cmd_first)
    else $error("Program or erase sent without write enable");

  property p_busy_on_output_enable_cmd_first;
    frame_go && (kind_q == flash_pkg::K_MAIN) && (op_q == flash_pkg::OP_AAI_FIRST) && hw_q
      |-> busy_on_output_enable_cmd_seen_q && write_enable_cmd_seen_q;
  endproperty
  a_busy_on_output_enable_cmd_first : assert property (p_busy_on_output_enable_cmd_first)
    else $error("Word programming started without busy output enable");

  property p_cs_low_byte;
    eng_busy |-> !cs_n_q && (st_q == flash_pkg::ST_BYTE);
  endproperty
  a_cs_low_byte : assert property (p_cs_low_byte)
    else $error("Chip select high while a byte shifts");

  property p_done_not_busy;
    done_q && (op_q != flash_pkg::OP_READ) |-> !stat_busy_q && cmd_ready_q;
  endproperty
  a_done_not_busy : assert property (p_done_not_busy)
    else $error("Write reported done while flash busy");

  property p_refuse_other;
    accept && aai_q && !is_aai_cmd |=> err_q && (st_q == flash_pkg::ST_IDLE);
  endproperty
  a_refuse_other : assert property (p_refuse_other)
    else $error("Disallowed command issued during word programming");

  property p_no_wrap;
    accept && (cmd_op == flash_pkg::OP_AAI_NEXT) && past_top |=> err_q ##1 cmd_ready_q;
  endproperty
  a_no_wrap : assert property (p_no_wrap)
    else $error("Word programming went past the top address");

  sequence s_write_disable_cmd_end;
    (st_q == flash_pkg::ST_CSHI) && (kind_q == flash_pkg::K_WRITE_DISABLE_CMD) && hw_q && gap_end;
  endsequence
  sequence s_busy_on_output_disable_cmd_frame;
    (st_q == flash_pkg::ST_CSLO) && (kind_q == flash_pkg::K_BUSY_ON_OUTPUT_DISABLE_CMD) && !cs_n_q;
  endsequence
  property p_write_disable_cmd_busy_on_output_disable_cmd;
    s_write_disable_cmd_end |=> s_busy_on_output_disable_cmd_frame;
  endproperty
  a_write_disable_cmd_busy_on_output_disable_cmd : assert property (p_write_disable_cmd_busy_on_output_disable_cmd)
    else $error("Busy output disable did not follow write disable");

  property p_ptr_step;
    (st_q == flash_pkg::ST_CSHI) && (kind_q == flash_pkg::K_MAIN)
      && (op_q == flash_pkg::OP_AAI_NEXT) && gap_end
      |=> ptr_q == $past(ptr_q) + flash_pkg::AAI_WORD_STEP;
  endproperty
  a_ptr_step : assert property (p_ptr_step)
    else $error("Word pointer did not advance by two");

endmodule : flash_host

/* include/flash_pkg.sv */
// Purpose: Constants and types for the serial flash host sequencer
// Assumes: 100 MHz system clock; flash runs SPI mode 0
// Notes:   Shared by flash_host and spi_byte_shifter
//
// Notes on behaviour
// - Fast read: opcode, 24-bit address MSB first, one dummy byte, then data.
// - Chip select stays low for the whole read; rising it ends the stream.
// - Host programs only erased bytes; device ignores protected targets.
// - Byte program: opcode, 24-bit address, one data byte, bit 7 first.
// - Write enable frame precedes every program or erase command.
// - Program completion learned by polling busy bit or waiting program time.
// - Next word goes only after busy clears; lands at next two addresses.
// - Continuation word: opcode and two data bytes, no address.
// - Word programming range must be erased; protected ranges ignored.
// - Host confirms not busy before the next command in word programming.
// - End word programming: write disable, then busy-output disable in hw mode.
// - Busy-output enable is issued before word programming starts; host sends it only when hw_detect is set.
// - Chip select low through all command bytes; operation starts on rise.
// - Erase completion learned by polling busy bit or waiting erase time.
package flash_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int SCK_HALF_NS   = 40;
  localparam int CS_SETUP_NS   = 20;
  localparam int CS_HIGH_NS    = 100;

  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_HIGH_CYC  = (CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] SCK_HALF_LAST = 8'(SCK_HALF_CYC - 1);
  localparam logic [7:0] CS_SETUP_LAST = 8'(CS_SETUP_CYC - 1);
  localparam logic [7:0] CS_HIGH_LAST  = 8'(CS_HIGH_CYC - 1);
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam logic [7:0] FAST_READ_CMD               = 8'h0b;
  localparam logic [7:0] BYTE_PROGRAM_CMD            = 8'h02;
  localparam logic [7:0] AAI_WORD_CMD                = 8'had;
  localparam logic [7:0] SECTOR_ERASE_CMD            = 8'h20;
  localparam logic [7:0] BLOCK32_ERASE_CMD           = 8'h52;
  localparam logic [7:0] BLOCK64_ERASE_CMD           = 8'hd8;
  localparam logic [7:0] WRITE_ENABLE_CMD            = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD           = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD             = 8'h05;
  localparam logic [7:0] BUSY_ON_OUTPUT_ENABLE_CMD   = 8'h70;
  localparam logic [7:0] BUSY_ON_OUTPUT_DISABLE_CMD  = 8'h80;
  localparam logic [7:0] DUMMY_BYTE                  = 8'h00;

  localparam logic [23:0] TOP_ADDRESS   = 24'h1fffff;
  localparam logic [23:0] SECTOR_MASK   = 24'hfff000;
  localparam logic [23:0] BLOCK32_MASK  = 24'hff8000;
  localparam logic [23:0] BLOCK64_MASK  = 24'hff0000;
  localparam logic [23:0] WORD_MASK     = 24'hfffffe;
  localparam logic [23:0] AAI_WORD_STEP = 24'h000002;
  localparam int          STAT_BUSY_BIT = 0;

  localparam logic [2:0] HDR_LEN_SHORT     = 3'h1;
  localparam logic [2:0] HDR_LEN_AAI_NEXT  = 3'h3;
  localparam logic [2:0] HDR_LEN_ERASE     = 3'h4;
  localparam logic [2:0] HDR_LEN_READ      = 3'h5;
  localparam logic [2:0] HDR_LEN_AAI_FIRST = 3'h6;

  typedef enum logic [2:0] {
    OP_READ      = 3'h0,
    OP_BYTE      = 3'h1,
    OP_AAI_FIRST = 3'h2,
    OP_AAI_NEXT  = 3'h3,
    OP_AAI_END   = 3'h4,
    OP_SECTOR    = 3'h5,
    OP_BLK32     = 3'h6,
    OP_BLK64     = 3'h7
  } user_op_t;

  typedef enum logic [2:0] {
    K_WRITE_ENABLE_CMD = 3'h0,
    K_BUSY_ON_OUTPUT_ENABLE_CMD = 3'h1,
    K_MAIN = 3'h2,
    K_POLL = 3'h3,
    K_WRITE_DISABLE_CMD = 3'h4,
    K_BUSY_ON_OUTPUT_DISABLE_CMD = 3'h5
  } frame_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CSLO = 3'h1,
    ST_BYTE = 3'h2,
    ST_CSHI = 3'h3,
    ST_HWW  = 3'h4
  } host_state_t;

endpackage : flash_pkg

/* hdl/spi_byte_shifter.sv */
// Purpose: Shift one byte out and in on the serial link, mode 0
// Assumes: miso already synchronised to clk
// Notes:   Serial clock made by a divider of clk
module spi_byte_shifter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] tx_byte,
  input  wire logic       miso,
  output logic            sck,
  output logic            mosi,
  output logic [7:0]      rx_byte,
  output logic            done,
  output logic            busy
);
  logic       active_q;
  logic       sck_q;
  logic       mosi_q;
  logic       done_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic [7:0] div_q;
  logic [2:0] bit_q;
  logic [3:0] rise_q;

  wire half_end = active_q && (div_q == flash_pkg::SCK_HALF_LAST);
  wire fall     = half_end && sck_q;
  wire rise     = half_end && !sck_q;
  wire last_bit = fall && (bit_q == 3'h7);

  always_ff @(posedge clk) begin
    if (rst) begin
      active_q <= 1'b0;
      sck_q    <= 1'b0;
      mosi_q   <= 1'b0;
      done_q   <= 1'b0;
      sh_q     <= 8'h00;
      rx_q     <= 8'h00;
      div_q    <= 8'h00;
      bit_q    <= 3'h0;
    end else begin
      done_q <= last_bit;
      if (start && !active_q) begin
        active_q <= 1'b1;
        sh_q     <= tx_byte;
        mosi_q   <= tx_byte[7];
        div_q    <= 8'h00;
        bit_q    <= 3'h0;
      end else if (active_q) begin
        div_q <= half_end ? 8'h00 : div_q + 8'h01;
        if (half_end) sck_q <= !sck_q;
        if (fall) begin
          rx_q   <= {rx_q[6:0], miso};
          bit_q  <= bit_q + 3'h1;
          sh_q   <= {sh_q[6:0], 1'b0};
          mosi_q <= sh_q[6];
        end
        if (last_bit) active_q <= 1'b0;
      end
    end
  end

  // Helper for checks: rising edges since start
  always_ff @(posedge clk) begin
    if (rst || (start && !active_q)) rise_q <= 4'h0;
    else if (rise) rise_q <= rise_q + 4'h1;
  end

  assign sck     = sck_q;
  assign mosi    = mosi_q;
  assign rx_byte = rx_q;
  assign done    = done_q;
  assign busy    = active_q;

  property p_eight_clocks;
    @(posedge clk) disable iff (rst) done_q |-> rise_q == flash_pkg::BITS_PER_BYTE;
  endproperty
  a_eight_clocks : assert property (p_eight_clocks)
    else $error("Byte did not take eight serial clocks");

  property p_sck_idle_low;
    @(posedge clk) disable iff (rst) $fell(active_q) |-> !sck_q && !active_q;
  endproperty
  a_sck_idle_low : assert property (p_sck_idle_low)
    else $error("Serial clock not low at byte end");

endmodule : spi_byte_shifter

/* tb/flash_model.sv */
// Purpose: Serial flash model on the host pins
// Assumes: Mode 0; unwritten bytes read ff
// Notes:   One busy time for all writes
module flash_model #(
  parameter int BUSY_NS = 3000
) (
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  output logic      so
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [int];
  logic [7:0]  sr, cmd = 8'h00, ob = 8'h00;
  logic [15:0] w2;
  logic [23:0] addr, ptr, msk;
  int          nb, n;
  logic        write_enable_latch = 1'b0, auto_increment_program = 1'b0, busy_on_output_enable_cmd = 1'b0, busy = 1'b0, ign = 1'b0;
  initial so = 1'b0;
  function automatic logic [7:0] peek(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : peek
  task automatic go();
    busy = 1'b1;
    busy <= #(BUSY_NS) 1'b0;
    if (!auto_increment_program) write_enable_latch = 1'b0;
  endtask : go
  always @(negedge busy) if (!cs_n && busy_on_output_enable_cmd) so = 1'b1;
  always @(negedge cs_n) begin
    nb = 0;
    n = 0;
    if (busy_on_output_enable_cmd && auto_increment_program) so = ~busy;
  end
  always @(posedge sck) if (!cs_n) begin
    sr = {sr[6:0], si};
    nb++;
    if (nb == 8) begin
      nb = 0;
      n++;
      w2 = {w2[7:0], sr};
      if (n == 1) cmd = sr;
      if (n == 1) ign = busy ? sr != 8'h05
                      : auto_increment_program && sr != 8'had && sr != 8'h04 && (sr != 8'h05 || busy_on_output_enable_cmd);
      if (n > 1 && n < 5 && !(auto_increment_program && cmd == 8'had)) addr = {addr[15:0], sr};
    end
  end
  always @(negedge sck) if (!cs_n && !ign && !(busy_on_output_enable_cmd && auto_increment_program)) begin
    if (nb == 0 && (cmd == 8'h05 ? n > 0 : cmd == 8'h0b && n > 4)) begin
      ob = cmd == 8'h05 ? {6'h00, write_enable_latch, busy} : peek(addr);
      if (cmd == 8'h0b) addr = (addr + 24'h1) & 24'h1fffff;
    end
    so = ob[7 - nb];
  end
  always @(posedge cs_n) begin
    so = ~so;
    if (!ign && nb == 0 && n > 0) begin
      msk = cmd == 8'h20 ? 24'hfff000 : cmd == 8'h52 ? 24'hff8000 : 24'hff0000;
      case (cmd)
        8'h06: write_enable_latch = 1'b1;
        8'h04: {write_enable_latch, auto_increment_program} = 2'b00;
        8'h70: busy_on_output_enable_cmd = 1'b1;
        8'h80: busy_on_output_enable_cmd = 1'b0;
        8'h02: if (write_enable_latch && n == 5) begin
          mem[addr] = peek(addr) & w2[7:0];
          go();
        end
        8'had: if (write_enable_latch && n == (auto_increment_program ? 3 : 6) && (!auto_increment_program || ptr < 24'h200000)) begin
          if (!auto_increment_program) ptr = addr & 24'h1ffffe;
          auto_increment_program = 1'b1;
          mem[ptr] = peek(ptr) & w2[15:8];
          mem[ptr + 24'h1] = peek(ptr + 24'h1) & w2[7:0];
          ptr = ptr + 24'h2;
          go();
        end
        8'h20, 8'h52, 8'hd8: if (write_enable_latch && n == 4) begin
          foreach (mem[k]) if ((24'(k) & msk) == (addr & msk)) mem[k] = 8'hff;
          go();
        end
        default: ;
      endcase
    end
  end
endmodule : flash_model

/* tb/tb.sv */
// Purpose: Self-checking bench for flash_host
// Assumes: flash_model on the serial pins
// Notes:   Writes judged by reading back
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                cmd_valid = 1'b0;
  flash_pkg::user_op_t cmd_op = flash_pkg::OP_READ;
  logic [23:0]         cmd_addr = 24'h000000;
  logic [15:0]         cmd_wdata = 16'h0000;
  logic [15:0]         cmd_len = 16'h0000;
  logic                hw_detect = 1'b0;
  logic                hw_sel = 1'b0;
  logic [7:0]          rd_data;
  logic                cmd_ready, rd_valid, done, err, aai_active;
  logic                flash_cs_n, flash_sck, flash_si, flash_so;
  logic [7:0]          rx [$];
  int                  n_fail = 0;
  int                  n_checks = 0;
  always #5 clk = ~clk;
  flash_host flash_host_inst (.clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
    .cmd_len, .hw_detect, .cmd_ready, .rd_data, .rd_valid, .done, .err, .aai_active,
    .flash_cs_n, .flash_sck, .flash_si, .flash_so);
  flash_model flash_model_inst (.cs_n(flash_cs_n), .sck(flash_sck), .si(flash_si),
    .so(flash_so));
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  task automatic issue(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d,
                       input logic e);
    logic fin;
    fin = 1'b0;
    rx.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= flash_pkg::user_op_t'(op);
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_len <= d;
    hw_detect <= hw_sel;
    for (int i = 0; i < 40000 && !fin; i++) begin
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      if (rd_valid === 1'b1) rx.push_back(rd_data);
      fin = done === 1'b1 || err === 1'b1;
    end
    if (!fin) begin
      n_fail++;
      summarize();
    end
    chk(16'(err), 16'(e));
    chk(16'(cmd_ready), 16'h0001);
  endtask : issue
  task automatic rdchk(input logic [23:0] a, input int n, input logic [31:0] x);
    issue(3'h0, a, 16'(n), 1'b0);
    chk(16'(rx.size()), 16'(n));
    foreach (rx[i]) chk(16'(rx[i]), 16'(x[8 * (n - 1 - i) +: 8]));
  endtask : rdchk
  task automatic s_program_erase;
    issue(3'h1, 24'h001fff, 16'h005a, 1'b0);
    issue(3'h1, 24'h002000, 16'h00a5, 1'b0);
    rdchk(24'h001fff, 2, 32'h5aa5);
    issue(3'h5, 24'h001abc, 16'h0000, 1'b0);
    rdchk(24'h001fff, 2, 32'hffa5);
  endtask : s_program_erase
  task automatic s_wrap_blocks;
    issue(3'h1, 24'h1fffff, 16'h003c, 1'b0);
    issue(3'h1, 24'h000000, 16'h00c3, 1'b0);
    rdchk(24'h1fffff, 2, 32'h3cc3);
    issue(3'h6, 24'h1f8001, 16'h0000, 1'b0);
    issue(3'h7, 24'h00ffff, 16'h0000, 1'b0);
    rdchk(24'h1fffff, 2, 32'hffff);
  endtask : s_wrap_blocks
  task automatic s_word(input logic [23:0] a, input logic hw);
    hw_sel = hw;
    issue(3'h2, a | 24'h1, 16'h1122, 1'b0);
    chk(16'(aai_active), 16'h0001);
    issue(3'h5, a, 16'h0000, 1'b1);
    issue(3'h3, a, 16'h3344, 1'b0);
    issue(3'h4, a, 16'h0000, 1'b0);
    chk(16'(aai_active), 16'h0000);
    issue(3'h3, a, 16'h5566, 1'b1);
    rdchk(a, 4, 32'h11223344);
  endtask : s_word
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    s_program_erase();
    s_wrap_blocks();
    s_word(24'h003000, 1'b0);
    s_word(24'h004000, 1'b1);
    summarize();
  end
endmodule : tb
